/* File: pda_cfg.svh */
`ifndef PDA_CFG_SVH
`define PDA_CFG_SVH

// ----------------------------------------------------------------
// function codes and contact polarity codes
// ----------------------------------------------------------------
`define PDA_FUNC_DEVIATION  8'h04
`define PDA_FUNC_ALARM      8'h05
`define PDA_POL_OPEN        2'h0
`define PDA_POL_CLOSED      2'h1

// ----------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------
`define PDA_VALUE_WIDTH     16
// process values and threshold in 0.1 percent steps: 3.0 percent
`define PDA_THRESH_DEFAULT  16'h001E
`define PDA_TIMER_WIDTH     32

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PDA_CLOCK_KHZ       100000
`define PDA_ALARM_DELAY_MS  300
// power-on contact delay must stay below 2 s, so take 1.5 s
`define PDA_POWERON_MS      1500
`define PDA_ALARM_DELAY_CYCLES (`PDA_ALARM_DELAY_MS * `PDA_CLOCK_KHZ)
`define PDA_POWERON_CYCLES     (`PDA_POWERON_MS * `PDA_CLOCK_KHZ)

`endif

/* File: pda_lag_timer.sv */
`timescale 1ns/1ps
`include "pda_cfg.svh"

// ----------------------------------------------------------------
// output follows input once the input has held for CYCLES clocks
// ----------------------------------------------------------------
module pda_lag_timer
  import pda_pkg::*;
#(
  parameter int CYCLES = 4,
  parameter int WIDTH  = `PDA_TIMER_WIDTH
) (
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic             d,
  output logic                  q,
  output logic [WIDTH-1:0]      count
);

  logic             q_reg;
  logic             q_next;
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;

  always_comb begin
    q_next     = q_reg;
    count_next = '0;
    if (d != q_reg) begin
      // a glitch shorter than the lag restarts the count
      if (count_reg >= WIDTH'(CYCLES - 1)) begin
        q_next = d;
      end else begin
        count_next = count_reg + WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      q_reg     <= 1'b0;
      count_reg <= '0;
    end else begin
      q_reg     <= q_next;
      count_reg <= count_next;
    end
  end

  assign q     = q_reg;
  assign count = count_reg;

endmodule : pda_lag_timer

/* File: pda_outputs.sv */
`timescale 1ns/1ps
`include "pda_cfg.svh"

// Notes on behaviour
// - error is absolute setpoint minus process value
// - deviation flag on when error above threshold
// - deviation flag off when error below threshold
// - threshold resets to three percent default
// - alarm routable to outputs eleven-fifteen or relay
// - alarm on while trip uncleared
// - alarm off when cleared, no fault
// - normally closed contact closes under two seconds
// - alarm stays valid without main power
// - alarm output lags internal alarm 300 ms
// - contact polarity code inverts relay logic
module pda_outputs
  import pda_pkg::*;
#(
  parameter int N_OC                = 5,
  parameter int ALARM_DELAY_CYCLES  = `PDA_ALARM_DELAY_CYCLES,
  parameter int POWERON_CYCLES      = `PDA_POWERON_CYCLES
) (
  input  wire logic                clock,
  input  wire logic                nrst,
  input  wire pda_value_type       setpoint,
  input  wire pda_value_type       process_value,
  input  wire pda_value_type       deviation_threshold_setting,
  input  wire logic                threshold_write,
  input  wire logic                trip_active,
  input  wire logic                fault_clear,
  input  wire logic                main_power_lost,
  input  wire logic [7:0]          oc_function_select [N_OC],
  input  wire logic [7:0]          relay_function_select,
  input  wire logic [1:0]          relay_contact_polarity,
  output logic [N_OC-1:0]          oc_out,
  output logic                     relay_first_contact,
  output logic                     relay_second_contact,
  output logic                     pid_deviation_flag,
  output logic                     fault_alarm_flag
);

  // ----------------------------------------------------------------
  // pid deviation
  // ----------------------------------------------------------------
  pda_value_type err_reg;
  pda_value_type err_next;
  pda_value_type thresh_reg;
  pda_value_type thresh_next;
  logic          dev_reg;
  logic          dev_next;
  logic          thresh_written_reg;
  logic          thresh_written_next;

  always_comb begin
    err_next = (setpoint >= process_value) ? (setpoint - process_value)
                                           : (process_value - setpoint);
    thresh_next         = thresh_reg;
    thresh_written_next = thresh_written_reg;
    if (threshold_write) begin
      thresh_next         = deviation_threshold_setting;
      thresh_written_next = 1'b1;
    end
    dev_next = dev_reg;
    if (err_reg > thresh_reg) begin
      dev_next = 1'b1;
    end else if (err_reg < thresh_reg) begin
      dev_next = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      err_reg            <= '0;
      thresh_reg         <= `PDA_THRESH_DEFAULT;
      dev_reg            <= 1'b0;
      thresh_written_reg <= 1'b0;
    end else begin
      err_reg            <= err_next;
      thresh_reg         <= thresh_next;
      dev_reg            <= dev_next;
      thresh_written_reg <= thresh_written_next;
    end
  end

  // ----------------------------------------------------------------
  // fault alarm
  // ----------------------------------------------------------------
  logic                        alarm_reg;
  logic                        alarm_next;
  logic                        alarm_out;
  logic                        relay_ready;
  logic [`PDA_TIMER_WIDTH-1:0] alarm_lag;

  always_comb begin
    alarm_next = alarm_reg;
    // trip wins over a clear that lands in the same cycle
    if (trip_active) begin
      alarm_next = 1'b1;
    end else if (fault_clear) begin
      alarm_next = 1'b0;
    end
  end

  // main_power_lost is left out on purpose: the control supply keeps
  // this logic alive, so the alarm stays as it is
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      alarm_reg <= 1'b0;
    end else begin
      alarm_reg <= alarm_next;
    end
  end

  pda_lag_timer #(
    .CYCLES (ALARM_DELAY_CYCLES)
  ) u_alarm_lag (
    .clock (clock),
    .nrst  (nrst),
    .d     (alarm_reg),
    .q     (alarm_out),
    .count (alarm_lag)
  );

  pda_lag_timer #(
    .CYCLES (POWERON_CYCLES)
  ) u_poweron (
    .clock (clock),
    .nrst  (nrst),
    .d     (1'b1),
    .q     (relay_ready),
    .count ()
  );

  // ----------------------------------------------------------------
  // output routing
  // ----------------------------------------------------------------
  function automatic logic pda_route(input logic [7:0] code,
                                     input logic       dev,
                                     input logic       alm);
    logic r;
    r = 1'b0;
    if (code == `PDA_FUNC_DEVIATION) begin
      r = dev;
    end else if (code == `PDA_FUNC_ALARM) begin
      r = alm;
    end
    return r;
  endfunction : pda_route

  logic relay_src;
  logic first_closed;

  always_comb begin
    for (int i = 0; i < N_OC; i++) begin
      oc_out[i] = pda_route(oc_function_select[i], dev_reg, alarm_out);
    end
    relay_src = pda_route(relay_function_select, dev_reg, alarm_out);
    // unpowered, the contact rests with first pair open either way
    if (!relay_ready) begin
      first_closed = 1'b0;
    end else if (relay_contact_polarity == `PDA_POL_OPEN) begin
      first_closed = relay_src;
    end else begin
      first_closed = !relay_src;
    end
  end

  assign relay_first_contact  = first_closed;
  assign relay_second_contact = !first_closed;
  assign pid_deviation_flag   = dev_reg;
  assign fault_alarm_flag     = alarm_out;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_above;
    err_reg > thresh_reg;
  endsequence

  sequence s_trip_then_clear;
    trip_active ##1 (fault_clear && !trip_active);
  endsequence

  AST_ERR_ABS: assert property (
    ##1 (err_reg == (($past(setpoint) >= $past(process_value))
          ? $past(setpoint) - $past(process_value)
          : $past(process_value) - $past(setpoint))))
    else $error("error magnitude wrong");

  AST_DEV_ON: assert property (s_above |=> pid_deviation_flag)
    else $error("deviation flag not set above threshold");

  AST_DEV_OFF: assert property (
    (err_reg < thresh_reg) |=> !pid_deviation_flag)
    else $error("deviation flag not cleared below threshold");

  AST_DEV_HOLD: assert property (
    (err_reg == thresh_reg) |=> $stable(pid_deviation_flag))
    else $error("deviation flag moved at equal error");

  AST_THRESH_DEFAULT: assert property (
    !thresh_written_reg |-> (thresh_reg == `PDA_THRESH_DEFAULT))
    else $error("threshold lost default before write");

  AST_ROUTE_OC0: assert property (
    (oc_function_select[0] == `PDA_FUNC_ALARM) |-> (oc_out[0] == alarm_out))
    else $error("alarm not routed to first open collector");

  AST_ALARM_SET: assert property (
    trip_active |=> alarm_reg [*2] or (alarm_reg ##1 !trip_active))
    else $error("internal alarm not held during trip");

  AST_ALARM_CLEAR: assert property (
    s_trip_then_clear |=> !alarm_reg)
    else $error("internal alarm not released on clear");

  AST_NO_POWER_EFFECT: assert property (
    (main_power_lost && !trip_active && !fault_clear) |=> $stable(alarm_reg))
    else $error("alarm changed on main power loss");

  AST_ALARM_LAG: assert property (
    alarm_lag < `PDA_TIMER_WIDTH'(ALARM_DELAY_CYCLES))
    else $error("alarm lag counter overran");

  AST_ALARM_FOLLOW: assert property (
    $changed(fault_alarm_flag) |-> $past(alarm_reg) == fault_alarm_flag)
    else $error("alarm output changed without cause");

  AST_POWERON: assert property (
    !relay_ready |-> (!relay_first_contact && relay_second_contact))
    else $error("contact closed before power-on delay");

  AST_POLARITY: assert property (
    (relay_ready && relay_contact_polarity == `PDA_POL_CLOSED)
      |-> (relay_first_contact == !relay_src))
    else $error("normally closed contact logic wrong");

endmodule : pda_outputs

/* File: pda_pkg.sv */
`include "pda_cfg.svh"

package pda_pkg;

  typedef enum logic [7:0] {
    PDA_FN_DEVIATION = `PDA_FUNC_DEVIATION,
    PDA_FN_ALARM     = `PDA_FUNC_ALARM
  } pda_func_type;

  typedef enum logic [1:0] {
    PDA_POL_OPEN   = `PDA_POL_OPEN,
    PDA_POL_CLOSED = `PDA_POL_CLOSED
  } pda_pol_type;

  typedef logic [`PDA_VALUE_WIDTH-1:0] pda_value_type;

endpackage : pda_pkg

/* File: pda_plc_input.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------
// plc input wired across common and first contact
// ----------------------------------------------------------------
module pda_plc_input (
  input  wire logic relay_first_contact,
  input  wire logic relay_second_contact,
  output logic      plc_level
);
  // an open contact reads 0 through the input pull-down; both closed
  // at once is a broken relay, so it also reads 0
  assign plc_level = relay_first_contact & ~relay_second_contact;
endmodule : pda_plc_input

/* File: tb.sv */
`timescale 1ns/1ps

module tb;
  import pda_pkg::*;
  logic          clock = 1'b0;
  logic          nrst  = 1'b0;
  pda_value_type sp    = 16'h0000;
  pda_value_type pv    = 16'h0000;
  pda_value_type thr   = 16'h0000;
  logic          wr    = 1'b0;
  logic          trip  = 1'b0;
  logic          clr   = 1'b0;
  logic          plost = 1'b0;
  logic [7:0]    ocsel [5] = '{default: 8'h00};
  logic [7:0]    rsel  = 8'h05;
  logic [1:0]    pol   = 2'h1;
  logic [4:0]    oc;
  logic          r1, r2, dev, alm, plc;
  int            fails = 0, n_tests = 0, mthr = 30, mflag = 0;
  logic [31:0]   seed  = 32'h6b8d_5f7b;

  always #5 clock = ~clock;

  pda_outputs #(.ALARM_DELAY_CYCLES(8), .POWERON_CYCLES(5)) i_dut (
    .clock(clock), .nrst(nrst), .setpoint(sp), .process_value(pv),
    .deviation_threshold_setting(thr), .threshold_write(wr),
    .trip_active(trip), .fault_clear(clr), .main_power_lost(plost),
    .oc_function_select(ocsel), .relay_function_select(rsel),
    .relay_contact_polarity(pol), .oc_out(oc),
    .relay_first_contact(r1), .relay_second_contact(r2),
    .pid_deviation_flag(dev), .fault_alarm_flag(alm)
  );

  pda_plc_input i_plc (
    .relay_first_contact(r1), .relay_second_contact(r2), .plc_level(plc)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string       nm,
                     input logic [15:0] e,
                     input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  // model: error magnitude against threshold, equal keeps the state
  task automatic dev_step(input int a, input int b);
    int err;
    sp = a[15:0];
    pv = b[15:0];
    cyc(2);
    err = (a > b) ? a - b : b - a;
    if (err > mthr) mflag = 1;
    else if (err < mthr) mflag = 0;
    chk("deviation", 16'(mflag), {15'h0000, dev});
    chk("oc deviation", 16'(mflag), {15'h0000, oc[1]});
  endtask : dev_step

  // bounded wait on the lagged alarm; a lag far from 8 cycles is wrong
  task automatic wait_alarm(input logic lvl);
    int n;
    n = 0;
    while (alm !== lvl && n < 20) begin
      cyc(1);
      n++;
    end
    if (n == 20) begin
      fails++;
      $display("FAIL alarm wait expected %h seen %h", lvl, alm);
      tally_and_finish();
    end else begin
      chk("alarm lag", 16'h0001, {15'h0000, n >= 8 && n <= 10});
    end
  endtask : wait_alarm

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(2);
    chk("reset oc", 16'h0000, {11'h000, oc});
    chk("reset relay", 16'h0001, {14'h0000, r1, r2});
    nrst = 1'b1;
    cyc(3);
    chk("poweron early", 16'h0000, {15'h0000, r1});
    cyc(4);
    chk("poweron closed", 16'h0002, {14'h0000, r1, r2});
    chk("plc level", 16'h0001, {15'h0000, plc});
    ocsel[1] = 8'h04;
    dev_step(100, 131);
    dev_step(131, 100);
    dev_step(100, 130);
    dev_step(100, 129);
    dev_step(130, 100);
    thr = 16'h0032;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
    mthr = 50;
    dev_step(0, 51);
    for (int i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      dev_step(seed[7:0], seed[15:8]);
    end
    ocsel = '{8'h05, 8'h04, 8'h07, 8'h00, 8'hff};
    trip = 1'b1;
    cyc(3);
    trip = 1'b0;
    clr = 1'b1;
    cyc(12);
    clr = 1'b0;
    chk("short trip", 16'h0000, {15'h0000, alm});
    trip = 1'b1;
    plost = 1'b1;
    wait_alarm(1'b1);
    cyc(3);
    chk("alarm held", 16'h0001, {15'h0000, alm});
    chk("oc alarm", 16'h0001, {11'h000, oc[4:2], 1'b0, oc[0]});
    chk("relay nc trip", 16'h0001, {14'h0000, r1, r2});
    pol = 2'h0;
    cyc(1);
    chk("relay no trip", 16'h0002, {14'h0000, r1, r2});
    for (int i = 0; i < 5; i++) ocsel[i] = 8'h05;
    cyc(1);
    chk("all oc alarm", 16'h001f, {11'h000, oc});
    trip = 1'b0;
    clr = 1'b1;
    wait_alarm(1'b0);
    chk("cleared oc", 16'h0000, {11'h000, oc});
    chk("cleared relay", 16'h0001, {14'h0000, r1, r2});
    clr = 1'b0;
    cyc(4);
    chk("power lost idle", 16'h0000, {15'h0000, alm});
    rsel = 8'h04;
    cyc(1);
    chk("relay deviation", 16'(mflag + 1), {14'h0000, r1, r2});
    tally_and_finish();
  end
endmodule : tb
